/* src/lppc_pkg.sv */
// Package: register map, field layout and timing for the pulse counter
package lppc_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam int          ADDR_W       = 6;
  localparam logic [5:0]  OFS_MODE     = 6'h00; // Master mode
  localparam logic [5:0]  OFS_PULLUP   = 6'h04; // Pull-up configuration
  localparam logic [5:0]  OFS_DEB_HIGH = 6'h08; // Rising threshold
  localparam logic [5:0]  OFS_DEB_LOW  = 6'h0C; // Falling threshold
  localparam logic [5:0]  OFS_CMP0     = 6'h10; // Threshold, counter 0
  localparam logic [5:0]  OFS_CMP1     = 6'h14; // Threshold, counter 1
  localparam logic [5:0]  OFS_COUNT0   = 6'h18; // Counter 0, read only
  localparam logic [5:0]  OFS_COUNT1   = 6'h1C; // Counter 1, read only
  localparam logic [5:0]  OFS_IRQ_STAT = 6'h20; // Sticky events, W1C
  localparam logic [5:0]  OFS_IRQ_MASK = 6'h24; // Event mask
  localparam logic [5:0]  OFS_LEVELS   = 6'h28; // Debounced levels

  // Field positions
  localparam int MODE_LSB    = 6;  // Mode field 7:6
  localparam int RATE_LSB    = 4;  // Sample-rate field 5:4
  localparam int STRENGTH_LSB = 2; // Pull-up strength 4:2
  localparam int DUTY_LSB    = 0;  // Pull-up duty 1:0

  // Event bits in status and mask
  localparam int EV_W     = 4;
  localparam int EV_OVF0  = 0;
  localparam int EV_OVF1  = 1;
  localparam int EV_CMP0  = 2;
  localparam int EV_CMP1  = 3;

  // Counter limits and reset values
  localparam logic [23:0] COUNT_MAX    = 24'hFFFFFF;
  localparam logic [23:0] CMP_RESET    = 24'hFFFFFF;
  localparam logic [7:0]  DEB_RESET    = 8'h04;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Sampling timing on the real-time clock
  localparam int RTC_PERIOD_NS   = 30518;  // 32.768 kHz
  localparam int SAMPLE_BASE_NS  = 250000; // Fastest interval, 250 us
  localparam int BASE_TICKS      = SAMPLE_BASE_NS / RTC_PERIOD_NS;
  localparam int EIGHTHS         = 8;      // Duty unit is 1/8 base interval

  // Counting modes
  typedef enum logic [1:0] {
    LPPC_OFF    = 2'h0,
    LPPC_SINGLE = 2'h1,
    LPPC_DUAL   = 2'h2,
    LPPC_QUAD   = 2'h3
  } lppc_mode_t;

  // Global configuration bundle
  typedef struct packed {
    lppc_mode_t  mode;     // Counting mode
    logic [1:0]  rate;     // Sample interval scale
    logic [2:0]  strength; // Pull-up current code
    logic [1:0]  duty;     // Pull-up duty code
    logic [7:0]  deb_high; // High samples to go high
    logic [7:0]  deb_low;  // Low samples to go low
    logic [23:0] cmp0;     // Threshold 0
    logic [23:0] cmp1;     // Threshold 1
  } lppc_cfg_t;

endpackage : lppc_pkg

/* src/lppc_top.sv */
// Low-power pulse counter: sampling, debounce, counters, AXI4-Lite regs
module lppc_top
  import lppc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic              rtc_sample_clock,
  input  wire logic              count_input_a,
  input  wire logic              count_input_b,
  output logic                   pullup_en,
  output logic [2:0]             pullup_strength,
  output logic                   irq,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] lppc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int k = 0; k < 4; k++)
    begin
      if (strb[k])
        res[k*8 +: 8] = new_v[k*8 +: 8];
    end
    return res;
  endfunction : lppc_merge

  // Next clockwise state, pair written as {b, a}
  function automatic logic [1:0] lppc_cw_next(input logic [1:0] s);
    logic [1:0] n;
    case (s)
      2'h0:    n = 2'h2;  // LL -> HL
      2'h2:    n = 2'h3;  // HL -> HH
      2'h3:    n = 2'h1;  // HH -> LH
      default: n = 2'h0;  // LH -> LL
    endcase
    return n;
  endfunction : lppc_cw_next

  localparam logic [6:0] BASE_T = 7'(BASE_TICKS);  // Ticks per 250 us

  // Synchronisers: {rtc, b, a}
  logic [2:0]  sync1;        // First stage only
  logic [2:0]  sync2;        // Safe levels
  logic        rtc_prev;     // Last RTC level
  logic        rtc_tick;     // One cycle per RTC rising edge
  logic [6:0]  phase;        // Position in sample interval
  logic [6:0]  next_phase;
  logic [6:0]  interval;     // Ticks per sample interval
  logic [6:0]  on_ticks;     // Ticks of pull-up charging
  logic        sample_now;   // Sample strobe after charging
  logic        next_pullup;
  logic        cfg_clear;    // Mode register write this cycle

  // Configuration, counters, flags
  lppc_cfg_t   cfg;
  lppc_cfg_t   next_cfg;
  logic [23:0] cnt0;
  logic [23:0] cnt1;
  logic [23:0] next_cnt0;
  logic [23:0] next_cnt1;
  logic [EV_W-1:0] flags;    // Sticky events
  logic [EV_W-1:0] next_flags;
  logic [EV_W-1:0] mask;     // Interrupt mask
  logic [EV_W-1:0] next_mask;
  logic [EV_W-1:0] events;   // Events this cycle
  logic [1:0]  filt;         // Debounced levels {b, a}
  logic [1:0]  filt_prev;    // Previous debounced levels
  logic        inc0;
  logic        inc1;

  // Sampling interval: base scaled by rate, duty in eighths of base
  always_comb
  begin
    interval = BASE_T << cfg.rate;
    case (cfg.duty)
      2'h0:    on_ticks = 7'((BASE_TICKS * 2) / EIGHTHS);
      2'h1:    on_ticks = 7'((BASE_TICKS * 3) / EIGHTHS);
      2'h2:    on_ticks = 7'((BASE_TICKS * 4) / EIGHTHS);
      default: on_ticks = 7'((BASE_TICKS * 6) / EIGHTHS);
    endcase
    rtc_tick   = sync2[2] & ~rtc_prev;
    sample_now = rtc_tick && (phase == on_ticks);
    next_phase = phase;
    if (cfg_clear || cfg.mode == LPPC_OFF)
      next_phase = 7'h00;
    else if (rtc_tick)
      next_phase = (phase >= interval - 7'h01) ? 7'h00 : phase + 7'h01;
    // Pull-up only while charging and a current is chosen
    next_pullup = (cfg.mode != LPPC_OFF) && (cfg.strength != 3'h0)
                  && (next_phase < on_ticks);
  end

  // Synchroniser and timing registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sync1     <= 3'h0;
      sync2     <= 3'h0;
      rtc_prev  <= 1'b0;
      phase     <= 7'h00;
      pullup_en <= 1'b0;
    end
    else
    begin
      sync1     <= {rtc_sample_clock, count_input_b, count_input_a};
      sync2     <= sync1;
      rtc_prev  <= sync2[2];
      phase     <= next_phase;
      pullup_en <= next_pullup;
    end
  end

  // One debounce integrator per input, same thresholds for both
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    logic [7:0] integ;       // Net opposing samples
    logic [7:0] next_integ;
    logic       lvl;         // Debounced output
    logic       next_lvl;
    logic [7:0] th_up;
    logic [7:0] th_dn;

    // Opposing samples count up, agreeing ones count down
    always_comb
    begin
      th_up      = (cfg.deb_high == 8'h00) ? 8'h01 : cfg.deb_high;
      th_dn      = (cfg.deb_low == 8'h00) ? 8'h01 : cfg.deb_low;
      next_integ = integ;
      next_lvl   = lvl;
      if (cfg_clear)
      begin
        next_integ = 8'h00;
        next_lvl   = sync2[i];
      end
      else if (sample_now)
      begin
        if (sync2[i] != lvl)
        begin
          if (integ + 8'h01 >= (lvl ? th_dn : th_up))
          begin
            next_integ = 8'h00;
            next_lvl   = sync2[i];
          end
          else
            next_integ = integ + 8'h01;
        end
        else if (integ != 8'h00)
          next_integ = integ - 8'h01;
      end
    end

    // Integrator state
    always_ff @(posedge sys_clk or posedge reset)
    begin
      if (reset)
      begin
        integ <= 8'h00;
        lvl   <= 1'b0;
      end
      else
      begin
        integ <= next_integ;
        lvl   <= next_lvl;
      end
    end

    assign filt[i] = lvl;
  end : g_ch

  // Counter steering by mode and event detection
  always_comb
  begin
    inc0 = 1'b0;
    inc1 = 1'b0;
    case (cfg.mode)
      LPPC_SINGLE:
        inc0 = filt[0] & ~filt_prev[0];
      LPPC_DUAL:
      begin
        inc0 = filt[0] & ~filt_prev[0];
        inc1 = filt[1] & ~filt_prev[1];
      end
      LPPC_QUAD:
      begin
        // Only adjacent steps count; others are dropped
        inc0 = (filt != filt_prev) && (filt == lppc_cw_next(filt_prev));
        inc1 = (filt != filt_prev) && (filt_prev == lppc_cw_next(filt));
      end
      default:
      begin
        inc0 = 1'b0;
        inc1 = 1'b0;
      end
    endcase
    next_cnt0 = cnt0 + {23'h000000, inc0};
    next_cnt1 = cnt1 + {23'h000000, inc1};
    if (cfg_clear)
    begin
      next_cnt0 = 24'h000000;
      next_cnt1 = 24'h000000;
    end
    events          = '0;
    events[EV_OVF0] = inc0 && (cnt0 == COUNT_MAX);
    events[EV_OVF1] = inc1 && (cnt1 == COUNT_MAX);
    events[EV_CMP0] = inc0 && (cnt0 + 24'h000001 == cfg.cmp0);
    events[EV_CMP1] = inc1 && (cnt1 + 24'h000001 == cfg.cmp1);
  end

  // Counter registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt0      <= 24'h000000;
      cnt1      <= 24'h000000;
      filt_prev <= 2'h0;
    end
    else
    begin
      cnt0      <= next_cnt0;
      cnt1      <= next_cnt1;
      filt_prev <= cfg_clear ? sync2[1:0] : filt;
    end
  end

  // AXI4-Lite slave state
  logic              aw_held;
  logic              next_aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic              w_held;
  logic              next_w_held;
  logic [31:0]       w_data;
  logic [31:0]       next_w_data;
  logic [3:0]        w_strb;
  logic [3:0]        next_w_strb;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              wr_fire;     // Address and data both present
  logic [31:0]       wr_val;      // Merged write value
  logic [31:0]       cur;         // Current image of written register

  // Ready terms: one write and one read outstanding
  assign s_axi_awready   = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready    = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready   = ~s_axi_rvalid;
  assign irq             = |(flags & mask);
  assign pullup_strength = cfg.strength;
  assign cfg_clear       = wr_fire && (aw_addr == OFS_MODE);

  // Bus decode, register writes and read mux
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    wr_fire     = aw_held & w_held & ~s_axi_bvalid;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp  = s_axi_bresp;
    next_cfg    = cfg;
    next_mask   = mask;
    next_flags  = flags;
    case (aw_addr)
      OFS_MODE:     cur = {24'h0, cfg.mode, cfg.rate, 4'h0};
      OFS_PULLUP:   cur = {27'h0, cfg.strength, cfg.duty};
      OFS_DEB_HIGH: cur = {24'h0, cfg.deb_high};
      OFS_DEB_LOW:  cur = {24'h0, cfg.deb_low};
      OFS_CMP0:     cur = {8'h0, cfg.cmp0};
      OFS_CMP1:     cur = {8'h0, cfg.cmp1};
      OFS_IRQ_MASK: cur = {28'h0, mask};
      default:      cur = 32'h0;
    endcase
    wr_val = lppc_merge(cur, w_data, w_strb);
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      case (aw_addr)
        OFS_MODE:
        begin
          // Defaults everywhere else, then new mode and rate
          next_cfg.strength = 3'h0;
          next_cfg.duty     = 2'h0;
          next_cfg.deb_high = DEB_RESET;
          next_cfg.deb_low  = DEB_RESET;
          next_cfg.cmp0     = CMP_RESET;
          next_cfg.cmp1     = CMP_RESET;
          next_mask         = '0;
          next_flags        = '0;
          next_cfg.mode     = lppc_mode_t'(wr_val[MODE_LSB +: 2]);
          next_cfg.rate     = wr_val[RATE_LSB +: 2];
        end
        OFS_PULLUP:
        begin
          next_cfg.strength = wr_val[STRENGTH_LSB +: 3];
          next_cfg.duty     = wr_val[DUTY_LSB +: 2];
        end
        OFS_DEB_HIGH: next_cfg.deb_high = wr_val[7:0];
        OFS_DEB_LOW:  next_cfg.deb_low  = wr_val[7:0];
        OFS_CMP0:     next_cfg.cmp0     = wr_val[23:0];
        OFS_CMP1:     next_cfg.cmp1     = wr_val[23:0];
        OFS_IRQ_MASK: next_mask         = wr_val[EV_W-1:0];
        OFS_IRQ_STAT: next_flags = flags & ~(w_data[EV_W-1:0]
                                   & {EV_W{w_strb[0]}});
        OFS_COUNT0, OFS_COUNT1, OFS_LEVELS:
          next_bresp = RESP_OKAY;   // Read-only, write ignored
        default:
          next_bresp = RESP_SLVERR; // Unmapped
      endcase
    end
    // New events win over a clear, not over a mode write
    if (!cfg_clear)
      next_flags = next_flags | events;
    // Read channel
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (s_axi_araddr)
        OFS_MODE:     next_rdata = {24'h0, cfg.mode, cfg.rate, 4'h0};
        OFS_PULLUP:   next_rdata = {27'h0, cfg.strength, cfg.duty};
        OFS_DEB_HIGH: next_rdata = {24'h0, cfg.deb_high};
        OFS_DEB_LOW:  next_rdata = {24'h0, cfg.deb_low};
        OFS_CMP0:     next_rdata = {8'h0, cfg.cmp0};
        OFS_CMP1:     next_rdata = {8'h0, cfg.cmp1};
        OFS_COUNT0:   next_rdata = {8'h0, cnt0};
        OFS_COUNT1:   next_rdata = {8'h0, cnt1};
        OFS_IRQ_STAT: next_rdata = {28'h0, flags};
        OFS_IRQ_MASK: next_rdata = {28'h0, mask};
        OFS_LEVELS:   next_rdata = {30'h0, filt};
        default:
        begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // Bus and register state
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= '0;
      w_held       <= 1'b0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
      cfg          <= '{mode: LPPC_OFF, rate: 2'h0, strength: 3'h0,
                        duty: 2'h0, deb_high: DEB_RESET,
                        deb_low: DEB_RESET, cmp0: CMP_RESET,
                        cmp1: CMP_RESET};
      mask         <= '0;
      flags        <= '0;
    end
    else
    begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      cfg          <= next_cfg;
      mask         <= next_mask;
      flags        <= next_flags;
    end
  end

endmodule : lppc_top

/* verif/lppc_meter.sv */
// Meter model: two-channel reed-switch encoder wheel
module lppc_meter
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [1:0] step_cmd, // 1 cw, 2 ccw, 3 jump two
  output logic            count_input_a,
  output logic            count_input_b
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] phase;      // Wheel position, clockwise order
  logic [1:0] next_phase; // Position after this step

  // Step the wheel; a jump skips a state on purpose
  always_comb
  begin
    case (step_cmd)
      2'h1:    next_phase = phase + 2'h1;
      2'h2:    next_phase = phase - 2'h1;
      2'h3:    next_phase = phase + 2'h2;
      default: next_phase = phase;
    endcase
  end

  // Wheel position register
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      phase <= 2'h0;
    else
      phase <= next_phase;
  end

  // Form-C contacts drive both levels; {b,a} runs 00,10,11,01
  assign count_input_b = phase[1] ^ phase[0];
  assign count_input_a = phase[1];
endmodule : lppc_meter

/* verif/lppc_top_sva.sv */
// Checker: port-level properties of the pulse counter
module lppc_top_sva
  import lppc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        rtc_sample_clock,
  input wire logic        pullup_en,
  input wire logic [2:0]  pullup_strength,
  input wire logic        irq,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  logic       rtc_q;    // Last RTC level
  logic [3:0] rtc_age;  // Cycles since RTC rose
  logic [3:0] hi_ticks; // RTC rises while pull-up on
  logic [3:0] bv_age;   // Cycles since a write answer
  logic       clean;    // Pull-up phase began without a write
  wire        quiet = (bv_age > 4'h3) && !s_axi_bvalid;

  // Helper counters
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rtc_q    <= 1'h0;
      rtc_age  <= 4'hF;
      hi_ticks <= 4'h0;
      bv_age   <= 4'hF;
      clean    <= 1'h0;
    end
    else
    begin
      rtc_q    <= rtc_sample_clock;
      rtc_age  <= (rtc_sample_clock && !rtc_q) ? 4'h0 :
                  (rtc_age == 4'hF) ? rtc_age : rtc_age + 4'h1;
      hi_ticks <= !pullup_en ? 4'h0 :
                  (rtc_sample_clock && !rtc_q) ? hi_ticks + 4'h1 : hi_ticks;
      bv_age   <= s_axi_bvalid ? 4'h0 :
                  (bv_age == 4'hF) ? bv_age : bv_age + 4'h1;
      clean    <= !pullup_en ? quiet : (clean && quiet);
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_strength_gate: assert property (
    (pullup_strength == 3'h0) [*2] |-> !pullup_en)
    else $error("pull-up on with zero strength");
  a_pullup_tick: assert property (
    $rose(pullup_en) && quiet |-> rtc_age <= 4'h6)
    else $error("pull-up rose away from an RTC tick");
  a_on_ticks: assert property (
    $fell(pullup_en) && clean && quiet |->
      hi_ticks >= 4'h2 && hi_ticks <= 4'h6)
    else $error("pull-up on-time outside duty range");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_unmapped_zero: assert property (
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered in time");
  a_write_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_reset_irq: assert property (
    $fell(reset) |-> !irq)
    else $error("interrupt high after reset");

  c_irq: cover property ($rose(irq));
  c_pulse: cover property ($fell(pullup_en) && clean);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : lppc_top_sva

bind lppc_top lppc_top_sva u_sva (
  .sys_clk(sys_clk), .reset(reset), .rtc_sample_clock(rtc_sample_clock),
  .pullup_en(pullup_en), .pullup_strength(pullup_strength), .irq(irq),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid));

/* verif/tb_low_power_pulse_counter.sv */
// Testbench: bus-driven scenarios for the pulse counter
module tb_low_power_pulse_counter import lppc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HOLD = 400; // Four samples plus sync
  localparam int ON_HI [4] = '{1280, 960, 640, 480}; // Pull-up cycles
  logic              sys_clk, reset, rtc_sample_clock, pullup_en, irq;
  logic [2:0]        pullup_strength;
  logic [1:0]        step_cmd;
  logic              count_input_a, count_input_b;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready;
  int                n_fail = 0, checks_done = 0, cyc = 0;
  int                hi_cnt = 0, h0;

  lppc_top u_dut (.sys_clk(sys_clk), .reset(reset),
    .rtc_sample_clock(rtc_sample_clock), .count_input_a(count_input_a),
    .count_input_b(count_input_b), .pullup_en(pullup_en),
    .pullup_strength(pullup_strength), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  lppc_meter u_meter (.sys_clk(sys_clk), .reset(reset), .step_cmd(step_cmd),
    .count_input_a(count_input_a), .count_input_b(count_input_b));

  // System clock, 100 MHz
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  // RTC ticks every ten cycles to keep the run short
  initial
  begin
    rtc_sample_clock = 1'h0;
    forever #50 rtc_sample_clock = ~rtc_sample_clock;
  end

  // Pull-up on-time and hang guard
  always @(posedge sys_clk)
  begin
    if (pullup_en === 1'h1)
      hi_cnt <= hi_cnt + 1;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task stop_test();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task chk_range(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask : chk_range

  task wr(input logic [5:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, b_hs;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'h1;
    b_hs = 1'h0;
    while (!b_hs)
    begin
      @(negedge sys_clk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs  = s_axi_wvalid && s_axi_wready;
      b_hs  = s_axi_bvalid;
      wr_resp = s_axi_bresp;
      @(posedge sys_clk);
      if (aw_hs)
        s_axi_awvalid <= 1'h0;
      if (w_hs)
        s_axi_wvalid <= 1'h0;
    end
  endtask : wr

  task rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic ar_hs, r_hs;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    r_hs = 1'h0;
    while (!r_hs)
    begin
      @(negedge sys_clk);
      ar_hs   = s_axi_arvalid && s_axi_arready;
      r_hs    = s_axi_rvalid;
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      @(posedge sys_clk);
      if (ar_hs)
        s_axi_arvalid <= 1'h0;
    end
    chk(rd_data, exp);
  endtask : rd_chk

  task step(input logic [1:0] c, input int n);
    step_cmd <= c;
    @(posedge sys_clk);
    step_cmd <= 2'h0;
    repeat (n) @(posedge sys_clk);
  endtask : step

  // One pulse on a (first step ccw) or on b (first step cw)
  task pulse(input logic [1:0] first);
    step(first, HOLD);
    step(~first, HOLD);
  endtask : pulse

  // Main sequence
  initial
  begin
    reset = 1'h1;
    step_cmd = 2'h0;
    s_axi_awaddr = 6'h0;
    s_axi_araddr = 6'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h1; // Answers always taken at once
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h1;
    repeat (16) @(posedge sys_clk);
    reset <= 1'h0;
    @(posedge sys_clk);
    // Reset defaults, unmapped slot
    rd_chk(OFS_DEB_HIGH, {24'h0, DEB_RESET});
    rd_chk(OFS_CMP1, {8'h0, CMP_RESET});
    rd_chk(6'h2C, 32'h0);
    chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
    wr(6'h2C, 32'h0);
    chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
    // Off mode counts nothing
    pulse(2'h2);
    rd_chk(OFS_COUNT0, 32'h0);
    // Single mode; short glitch is filtered
    wr(OFS_MODE, 32'h40);
    step(2'h2, 150);
    step(2'h1, HOLD);
    rd_chk(OFS_COUNT0, 32'h0);
    repeat (3) pulse(2'h2);
    pulse(2'h1);
    rd_chk(OFS_COUNT0, 32'h3);
    rd_chk(OFS_COUNT1, 32'h0);
    wr(OFS_COUNT0, 32'h55);
    chk({30'h0, wr_resp}, {30'h0, RESP_OKAY});
    rd_chk(OFS_COUNT0, 32'h3);
    // Threshold event, mask, W1C
    wr(OFS_CMP0, 32'h5);
    wr(OFS_IRQ_MASK, 32'h4);
    pulse(2'h2);
    chk({31'h0, irq}, 32'h0);
    pulse(2'h2);
    chk({31'h0, irq}, 32'h1);
    rd_chk(OFS_IRQ_STAT, 32'h4);
    wr(OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h4);
    chk({31'h0, irq}, 32'h0);
    // Dual mode after a mode write
    wr(OFS_MODE, 32'h80);
    rd_chk(OFS_COUNT0, 32'h0);
    rd_chk(OFS_CMP0, {8'h0, CMP_RESET});
    rd_chk(OFS_IRQ_MASK, 32'h0);
    wr(OFS_CMP1, 32'h2);
    pulse(2'h2);
    pulse(2'h1);
    pulse(2'h1);
    rd_chk(OFS_COUNT0, 32'h1);
    rd_chk(OFS_COUNT1, 32'h2);
    rd_chk(OFS_IRQ_STAT, 32'h8);
    // Quadrature: cw, ccw, then an illegal jump
    wr(OFS_MODE, 32'hC0);
    repeat (4) step(2'h1, HOLD);
    rd_chk(OFS_COUNT0, 32'h4);
    repeat (2) step(2'h2, HOLD);
    rd_chk(OFS_COUNT1, 32'h2);
    rd_chk(OFS_LEVELS, 32'h3);
    step(2'h3, HOLD);
    rd_chk(OFS_COUNT0, 32'h4);
    rd_chk(OFS_COUNT1, 32'h2);
    // Pull-up duty against sample rate
    for (int r = 0; r < 4; r++)
    begin
      wr(OFS_MODE, 32'h40 | (32'(r) << 4));
      wr(OFS_PULLUP, 32'h1C | 32'(r));
      chk({29'h0, pullup_strength}, 32'h7);
      h0 = hi_cnt;
      repeat (5120) @(posedge sys_clk);
      chk_range(hi_cnt - h0, ON_HI[r] - 70, ON_HI[r] + 70);
    end
    wr(OFS_PULLUP, 32'h3);
    @(posedge sys_clk); // Let the last registered enable drain
    h0 = hi_cnt;
    repeat (400) @(posedge sys_clk);
    chk_range(hi_cnt - h0, 0, 0);
    stop_test();
  end
endmodule : tb_low_power_pulse_counter
